// ---- gun_status_pkg.sv ----
// Constants shared by the gun status and job loader
package gun_status_pkg;
  localparam int          JOB_BITS      = 9;
  localparam int          JOB_W         = 8;
  localparam logic [7:0]  JOB_MIN       = 8'h01;
  localparam logic [7:0]  JOB_MAX       = 8'hc7;
  localparam logic [7:0]  WEIGHT_TEN    = 8'h0a;
  localparam logic [7:0]  WEIGHT_HUNDRED = 8'h64;
  localparam int          CLK_HZ        = 25000000;
  localparam int          FREQ_MAX_HZ   = 1500;
  localparam int          GATE_MS       = 100;
  localparam int          GATE_CYCLES   = CLK_HZ / 1000 * GATE_MS;
  localparam int          AMP_RST_US    = 10;
  localparam int          AMP_RST_CYCLES = CLK_HZ / 1000000 * AMP_RST_US;
  localparam int          FLOW_FULL_CC  = 2000;
  localparam int          CMD_W         = 12;
  localparam int          CNT_W         = 16;
  localparam int          TOT_W         = 32;
  // AXI register byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_FAULT_EN = 8'h04;
  localparam logic [7:0]  ADDR_RPM_MAX  = 8'h08;
  localparam logic [7:0]  ADDR_SPEED    = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  localparam logic [7:0]  ADDR_JOB      = 8'h14;
  localparam logic [7:0]  ADDR_FB_FREQ  = 8'h18;
  localparam logic [7:0]  ADDR_SOLV_TOT = 8'h1c;
  localparam logic [7:0]  ADDR_FLOW     = 8'h20;
  localparam logic [7:0]  ADDR_FAULT_IN = 8'h24;
  // Control register bits
  localparam int          CTRL_CFG_OK   = 0;
  localparam int          CTRL_MOTOR    = 1;
  localparam int          CTRL_POT_EXP  = 2;
  localparam int          CTRL_CLEAR    = 3;
  localparam int          CTRL_RUN      = 4;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef enum logic [1:0] {
    GUN_HALTED  = 2'b00,
    GUN_RUNNING = 2'b01,
    GUN_FAULTED = 2'b10
  } gun_state_e;
endpackage : gun_status_pkg

// ---- gun_status_job_loader.sv ----
// Gun channel status outputs, pulse counters and job loader with AXI4-Lite registers
// Summary of operation
// - Fault output on while any fault is present, alarm enabled or not
// - Spray shutdown and flow stop only for faults whose alarm is enabled
// - Ready only when configured, valid job loaded and running; off on fault
// - Flush request on when the pot-life timer has expired
// - Motor-on output high while the motor is under active control
// - Clear-faults or halt pulse gives a brief amplifier-reset pulse
// - Frequency inputs measured correctly up to 1.5 kHz square waves
// - Pump flow rate derived from measured motor-feedback frequency
// - Solvent meter pulses counted into a running usage total
// - Speed command linear: zero gives 0 RPM, full scale gives maximum RPM
// - Actual-flow output proportional to flow, full scale 2000 cc/min
// - Strobe rising edge captures the job-number inputs into the queue
// - Job captured while halted or faulted becomes active at once
// - Job captured while running waits until the next halt or fault
// - Pending queue is one deep; a later capture overwrites it
// - Job number decoded from weights 1,2,4,8,10,20,40,80,100
// - Job inputs shared and ignored except at a strobe event
// - Job numbers lie from 1 to 199
`timescale 1ns/1ps
`default_nettype none
module gun_status_job_loader #(
  parameter int FAULTS      = 8,
  parameter int GATE_CYCLES = gun_status_pkg::GATE_CYCLES,
  parameter int AMP_CYCLES  = gun_status_pkg::AMP_RST_CYCLES
) (
  // Clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic                                  clk_en,
  // AXI4-Lite write
  input  wire logic [7:0]                            s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                            s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  // Pins from outside
  input  wire logic [FAULTS-1:0]                     fault_cond,
  input  wire logic                                  halt_pulse,
  input  wire logic                                  gun_strobe,
  input  wire logic [gun_status_pkg::JOB_BITS-1:0]   job_in,
  input  wire logic                                  motor_fb,
  input  wire logic                                  solvent_pulse,
  // Status outputs
  output logic                                       fault_out,
  output logic                                       spray_shutdown,
  output logic                                       ready_out,
  output logic                                       flush_request,
  output logic                                       motor_on,
  output logic                                       amp_reset,
  output logic [gun_status_pkg::CMD_W-1:0]           speed_cmd,
  output logic [gun_status_pkg::CMD_W-1:0]           flow_out
);
  localparam int PIN_N = FAULTS + 4 + gun_status_pkg::JOB_BITS;
  localparam int CW = gun_status_pkg::CMD_W;
  localparam int NW = gun_status_pkg::CNT_W;
  localparam int TW = gun_status_pkg::TOT_W;
  localparam int JW = gun_status_pkg::JOB_W;

  // Three-stage synchronisers; change counts when stages two and three agree
  logic [PIN_N-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= '0;
    end else if (clk_en) begin
      s1_reg <= {fault_cond, halt_pulse, gun_strobe, motor_fb, solvent_pulse, job_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < PIN_N; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  logic [gun_status_pkg::JOB_BITS-1:0] job_s;
  logic                                solv_s, fb_s, strobe_s, halt_s;
  logic [FAULTS-1:0]                   flt_s;
  assign {flt_s, halt_s, strobe_s, fb_s, solv_s, job_s} = pin_reg;

  // Edge detect on synchronised pulses
  logic strobe_d, halt_d, fb_d, solv_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_d <= 1'b0;
      halt_d   <= 1'b0;
      fb_d     <= 1'b0;
      solv_d   <= 1'b0;
    end else if (clk_en) begin
      strobe_d <= strobe_s;
      halt_d   <= halt_s;
      fb_d     <= fb_s;
      solv_d   <= solv_s;
    end
  end
  wire strobe_rise = strobe_s & ~strobe_d;
  wire halt_rise   = halt_s & ~halt_d;
  wire fb_rise     = fb_s & ~fb_d;
  wire solv_rise   = solv_s & ~solv_d;

  // Decimal-coded job number decode
  function automatic logic [7:0] job_decode(input logic [8:0] b);
    job_decode = {4'h0, b[3:0]}
               + gun_status_pkg::WEIGHT_TEN * {4'h0, b[7:4]}
               + (b[8] ? gun_status_pkg::WEIGHT_HUNDRED : 8'h00);
  endfunction : job_decode

  // Software registers
  logic [31:0]     ctrl_reg, fault_en_reg;
  logic [15:0]     rpm_max_reg;
  logic [CW-1:0]   speed_reg;
  logic            clear_pulse;
  wire  [FAULTS-1:0] fault_en = fault_en_reg[FAULTS-1:0];

  // Gun state and faults
  gun_status_pkg::gun_state_e state_reg;
  wire any_fault   = |flt_s;
  wire fault_stop  = |(flt_s & fault_en);
  wire run_req     = ctrl_reg[gun_status_pkg::CTRL_RUN];
  logic [JW-1:0] job_act_reg, job_pend_reg;
  logic          pend_reg;
  wire  job_ok = (job_act_reg >= gun_status_pkg::JOB_MIN) &&
                 (job_act_reg <= gun_status_pkg::JOB_MAX);
  wire  halt_evt = halt_rise | clear_pulse;
  wire  cfg_ok   = ctrl_reg[gun_status_pkg::CTRL_CFG_OK];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= gun_status_pkg::GUN_HALTED;
    end else if (clk_en) begin
      unique case (state_reg)
        gun_status_pkg::GUN_HALTED: begin
          if (fault_stop) state_reg <= gun_status_pkg::GUN_FAULTED;
          else if (run_req && cfg_ok && job_ok) state_reg <= gun_status_pkg::GUN_RUNNING;
        end
        gun_status_pkg::GUN_RUNNING: begin
          if (fault_stop) state_reg <= gun_status_pkg::GUN_FAULTED;
          else if (halt_evt || !run_req) state_reg <= gun_status_pkg::GUN_HALTED;
        end
        gun_status_pkg::GUN_FAULTED: begin
          if (halt_evt && !fault_stop) state_reg <= gun_status_pkg::GUN_HALTED;
        end
        default: state_reg <= gun_status_pkg::GUN_HALTED;
      endcase
    end
  end
  wire running  = (state_reg == gun_status_pkg::GUN_RUNNING);
  wire leaving  = running && (fault_stop || halt_evt || !run_req);

  // Job queue
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      job_act_reg  <= '0;
      job_pend_reg <= '0;
      pend_reg     <= 1'b0;
    end else if (clk_en) begin
      if (strobe_rise) begin
        if (!running || leaving) begin
          job_act_reg <= job_decode(job_s);
          pend_reg    <= 1'b0;
        end else begin
          job_pend_reg <= job_decode(job_s);
          pend_reg     <= 1'b1;
        end
      end else if (pend_reg && leaving) begin
        job_act_reg <= job_pend_reg;
        pend_reg    <= 1'b0;
      end
    end
  end

  // Amplifier reset pulse
  logic [15:0] amp_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_cnt_reg <= '0;
    end else if (clk_en) begin
      if (halt_evt) amp_cnt_reg <= 16'(AMP_CYCLES);
      else if (amp_cnt_reg != '0) amp_cnt_reg <= amp_cnt_reg - 16'h0001;
    end
  end

  // Frequency measurement and solvent totaliser
  logic [31:0] gate_reg;
  logic [NW-1:0] fb_cnt_reg, fb_freq_reg;
  logic [TW-1:0] solv_tot_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_reg    <= '0;
      fb_cnt_reg  <= '0;
      fb_freq_reg <= '0;
    end else if (clk_en) begin
      if (gate_reg == 32'(GATE_CYCLES - 1)) begin
        gate_reg    <= '0;
        fb_freq_reg <= fb_cnt_reg + NW'(fb_rise);
        fb_cnt_reg  <= '0;
      end else begin
        gate_reg   <= gate_reg + 32'h1;
        fb_cnt_reg <= fb_cnt_reg + NW'(fb_rise);
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) solv_tot_reg <= '0;
    else if (clk_en && solv_rise) solv_tot_reg <= solv_tot_reg + TW'(1);
  end

  // Flow in cc/min from feedback count, clamped to full scale
  logic [CW-1:0] flow_cc;
  always_comb begin
    if (fb_freq_reg >= NW'(gun_status_pkg::FLOW_FULL_CC)) flow_cc = CW'(gun_status_pkg::FLOW_FULL_CC);
    else flow_cc = fb_freq_reg[CW-1:0];
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_out      <= 1'b0;
      spray_shutdown <= 1'b0;
      ready_out      <= 1'b0;
      flush_request  <= 1'b0;
      motor_on       <= 1'b0;
      amp_reset      <= 1'b0;
      speed_cmd      <= '0;
      flow_out       <= '0;
    end else if (clk_en) begin
      fault_out      <= any_fault;
      spray_shutdown <= fault_stop;
      ready_out      <= running && cfg_ok && job_ok && !any_fault;
      flush_request  <= ctrl_reg[gun_status_pkg::CTRL_POT_EXP];
      motor_on       <= ctrl_reg[gun_status_pkg::CTRL_MOTOR] && running;
      amp_reset      <= (amp_cnt_reg != '0);
      speed_cmd      <= running ? speed_reg : '0;
      flow_out       <= CW'((32'(flow_cc) * ((32'h1 << CW) - 32'h1))
                        / 32'(gun_status_pkg::FLOW_FULL_CC));
    end
  end

  // AXI4-Lite write channel
  logic [7:0]  aw_addr_reg;
  logic        aw_have, w_have;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gun_status_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_have && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg <= gun_status_pkg::ADDR_SPEED && aw_addr_reg[1:0] == 2'b00)
                        ? gun_status_pkg::RESP_OKAY : gun_status_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire wr_do = clk_en && aw_have && w_have && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= '0;
      fault_en_reg <= '0;
      rpm_max_reg  <= '0;
      speed_reg    <= '0;
      clear_pulse  <= 1'b0;
    end else if (clk_en) begin
      clear_pulse <= 1'b0;
      if (wr_do) begin
        unique case (aw_addr_reg)
          gun_status_pkg::ADDR_CTRL: begin
            ctrl_reg    <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'hfffffff7;
            clear_pulse <= w_strb_reg[0] && w_data_reg[gun_status_pkg::CTRL_CLEAR];
          end
          gun_status_pkg::ADDR_FAULT_EN: fault_en_reg <= merge(fault_en_reg, w_data_reg, w_strb_reg);
          gun_status_pkg::ADDR_RPM_MAX: rpm_max_reg <= w_data_reg[15:0];
          gun_status_pkg::ADDR_SPEED: speed_reg <= w_data_reg[CW-1:0];
          default: ;
        endcase
      end
    end
  end

  // AXI4-Lite read channel
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    unique case (a)
      gun_status_pkg::ADDR_CTRL:     rd_mux = ctrl_reg;
      gun_status_pkg::ADDR_FAULT_EN: rd_mux = fault_en_reg;
      gun_status_pkg::ADDR_RPM_MAX:  rd_mux = {16'h0000, rpm_max_reg};
      gun_status_pkg::ADDR_SPEED:    rd_mux = 32'(speed_reg);
      gun_status_pkg::ADDR_STATUS:   rd_mux = {24'h0, pend_reg, 1'b0, state_reg, ready_out,
                                               spray_shutdown, fault_out, amp_reset};
      gun_status_pkg::ADDR_JOB:      rd_mux = {16'h0, job_pend_reg, job_act_reg};
      gun_status_pkg::ADDR_FB_FREQ:  rd_mux = 32'(fb_freq_reg);
      gun_status_pkg::ADDR_SOLV_TOT: rd_mux = 32'(solv_tot_reg);
      gun_status_pkg::ADDR_FLOW:     rd_mux = 32'(flow_cc);
      gun_status_pkg::ADDR_FAULT_IN: rd_mux = 32'(flt_s);
      default:                       rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= gun_status_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux(s_axi_araddr);
        s_axi_rresp  <= (s_axi_araddr <= gun_status_pkg::ADDR_FAULT_IN && s_axi_araddr[1:0] == 2'b00)
                        ? gun_status_pkg::RESP_OKAY : gun_status_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Assertions
  a_fault_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> fault_out == $past(any_fault)) else $error("fault output wrong");
  a_shutdown_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    spray_shutdown |-> fault_out) else $error("shutdown without fault");
  a_ready_no_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && any_fault) |=> !ready_out) else $error("ready during fault");
  a_flush_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> flush_request == $past(ctrl_reg[gun_status_pkg::CTRL_POT_EXP]))
    else $error("flush request wrong");
  a_motor_run: assert property (@(posedge aclk) disable iff (!aresetn)
    motor_on |-> $past(running)) else $error("motor on while idle");
  sequence s_halt_seen;
    clk_en && halt_evt;
  endsequence
  a_amp_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_halt_seen |=> ##1 amp_reset) else $error("no amp reset pulse");
  a_solvent_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && solv_rise) |=> solv_tot_reg == $past(solv_tot_reg) + TW'(1))
    else $error("solvent count missed");
  a_job_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && strobe_rise && !running) |=> job_act_reg == $past(job_decode(job_s)))
    else $error("job not made active");
  a_job_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && strobe_rise && running && !leaving) |=> pend_reg && job_act_reg == $past(job_act_reg))
    else $error("job not held pending");
endmodule : gun_status_job_loader
`default_nettype wire

// ---- gun_line_ctrl.sv ----
// Line controller and meter model driving the gun channel pins
`timescale 1ns/1ps
`default_nettype none
module gun_line_ctrl (
  // Clock
  input  wire logic       aclk,
  // Pins to the gun channel
  output var  logic       gun_strobe,
  output var  logic [8:0] job_in,
  output var  logic       motor_fb,
  output var  logic       solvent_pulse
);
  // Strobe hold and spacing, scaled down from the real minimum
  localparam int HOLD = 20;
  initial begin
    gun_strobe = 1'b0;
    job_in = 9'h000;
    motor_fb = 1'b0;
    solvent_pulse = 1'b0;
  end
  function automatic logic [8:0] code(input int n);
    int h, t, u;
    h = n / 100;
    t = (n / 10) % 10;
    u = n % 10;
    return {h[0], t[3:0], u[3:0]};
  endfunction : code
  task automatic load_job(input int n);
    @(posedge aclk);
    job_in <= code(n);
    repeat (HOLD) @(posedge aclk);
    gun_strobe <= 1'b1;
    repeat (HOLD) @(posedge aclk);
    gun_strobe <= 1'b0;
    job_in <= ~code(n);
    repeat (HOLD) @(posedge aclk);
  endtask : load_job
  // Scaled pulse rate; trains stay well inside what the inputs can follow
  task automatic pulses(input bit solv, input int count, input int half);
    repeat (count) begin
      repeat (half) @(posedge aclk);
      if (solv) solvent_pulse <= 1'b1;
      else motor_fb <= 1'b1;
      repeat (half) @(posedge aclk);
      if (solv) solvent_pulse <= 1'b0;
      else motor_fb <= 1'b0;
    end
  endtask : pulses
endmodule : gun_line_ctrl
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the gun status and job loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int AMP = 4;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  fault_cond = 8'h00;
  logic        clk_en = 1'b1;
  logic [3:0]  wstrb = 4'hf;
  logic        halt_pulse = 1'b0;
  logic        gun_strobe, motor_fb, solvent_pulse;
  logic [8:0]  job_in;
  logic        fault_out, spray_shutdown, ready_out, flush_request, motor_on, amp_reset;
  logic [11:0] speed_cmd, flow_out;
  int          bad_count = 0, compares = 0, amp_hi = 0, amp_base = 0;
  int          jobs[5] = '{1, 42, 99, 100, 199};
  always #20 aclk = ~aclk;
  always @(posedge aclk) if (amp_reset === 1'b1) amp_hi <= amp_hi + 1;
  gun_status_job_loader #(.FAULTS(8), .GATE_CYCLES(100), .AMP_CYCLES(AMP)) dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_cond(fault_cond), .halt_pulse(halt_pulse), .gun_strobe(gun_strobe),
    .job_in(job_in), .motor_fb(motor_fb), .solvent_pulse(solvent_pulse),
    .fault_out(fault_out), .spray_shutdown(spray_shutdown), .ready_out(ready_out),
    .flush_request(flush_request), .motor_on(motor_on), .amp_reset(amp_reset),
    .speed_cmd(speed_cmd), .flow_out(flow_out));
  gun_line_ctrl m (.aclk(aclk), .gun_strobe(gun_strobe), .job_in(job_in),
    .motor_fb(motor_fb), .solvent_pulse(solvent_pulse));
  task automatic bad(input string w);
    bad_count++;
    $display("BAD %0t %s", $time, w);
  endtask : bad
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) bad(w);
  endtask : chk
  task automatic chk1(input logic got, input logic exp, input string w);
    compares++;
    if (got !== exp) bad(w);
  endtask : chk1
  task automatic near(input logic [31:0] got, input int exp, input int tol, input string w);
    compares++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) bad(w);
  endtask : near
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "write response");
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic rchk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    axr(a);
    chk(rd & mk, e, "register read");
  endtask : rchk
  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    #(40 * 20000);
    bad("watchdog expired");
    final_report();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2);
    rchk(gun_status_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
    rchk(gun_status_pkg::ADDR_JOB, 32'hffffffff, 32'h0);
    axr(8'h28);
    chk(32'(rs), 32'(gun_status_pkg::RESP_SLVERR), "unmapped read");
    axw(gun_status_pkg::ADDR_STATUS, 32'h1, gun_status_pkg::RESP_SLVERR);
    foreach (jobs[i]) begin
      m.load_job(jobs[i]);
      rchk(gun_status_pkg::ADDR_JOB, 32'hff, 32'(jobs[i]));
    end
    axw(gun_status_pkg::ADDR_FAULT_EN, 32'h0, gun_status_pkg::RESP_OKAY);
    axw(gun_status_pkg::ADDR_SPEED, 32'h800, gun_status_pkg::RESP_OKAY);
    axw(gun_status_pkg::ADDR_CTRL, 32'h13, gun_status_pkg::RESP_OKAY);
    wt(8);
    chk1(ready_out, 1'b1, "ready while running");
    chk1(motor_on, 1'b1, "motor on while running");
    chk(32'(speed_cmd), 32'h800, "speed mid");
    rchk(gun_status_pkg::ADDR_STATUS, 32'h30, 32'h10);
    axw(gun_status_pkg::ADDR_SPEED, 32'h0, gun_status_pkg::RESP_OKAY);
    wt(4);
    chk(32'(speed_cmd), 32'h0, "speed zero");
    axw(gun_status_pkg::ADDR_SPEED, 32'hfff, gun_status_pkg::RESP_OKAY);
    wt(4);
    chk(32'(speed_cmd), 32'hfff, "speed full");
    m.load_job(5);
    m.load_job(7);
    rchk(gun_status_pkg::ADDR_JOB, 32'hffff, 32'h07c7);
    @(posedge aclk);
    amp_base = amp_hi;
    halt_pulse <= 1'b1;
    wt(20);
    halt_pulse <= 1'b0;
    wt(20);
    chk(32'(amp_hi - amp_base), 32'(AMP), "amp reset on halt");
    rchk(gun_status_pkg::ADDR_JOB, 32'hff, 32'h7);
    axw(gun_status_pkg::ADDR_CTRL, 32'h0, gun_status_pkg::RESP_OKAY);
    wt(8);
    chk1(motor_on, 1'b0, "motor off when stopped");
    chk1(ready_out, 1'b0, "ready off when stopped");
    axw(gun_status_pkg::ADDR_CTRL, 32'h13, gun_status_pkg::RESP_OKAY);
    wt(8);
    fault_cond <= 8'h01;
    wt(10);
    chk1(fault_out, 1'b1, "fault with alarm off");
    chk1(spray_shutdown, 1'b0, "no shutdown with alarm off");
    chk1(motor_on, 1'b1, "flow kept with alarm off");
    chk1(ready_out, 1'b0, "ready off on fault");
    axw(gun_status_pkg::ADDR_FAULT_EN, 32'h2, gun_status_pkg::RESP_OKAY);
    fault_cond <= 8'h03;
    wt(10);
    chk1(spray_shutdown, 1'b1, "shutdown with alarm on");
    chk1(motor_on, 1'b0, "flow stopped with alarm on");
    fault_cond <= 8'h00;
    wt(10);
    chk1(fault_out, 1'b0, "fault gone");
    @(posedge aclk);
    amp_base = amp_hi;
    axw(gun_status_pkg::ADDR_CTRL, 32'h08, gun_status_pkg::RESP_OKAY);
    wt(12);
    chk(32'(amp_hi - amp_base), 32'(AMP), "amp reset on clear");
    axw(gun_status_pkg::ADDR_CTRL, 32'h04, gun_status_pkg::RESP_OKAY);
    wt(3);
    chk1(flush_request, 1'b1, "flush on expiry");
    axw(gun_status_pkg::ADDR_CTRL, 32'h0, gun_status_pkg::RESP_OKAY);
    wt(3);
    chk1(flush_request, 1'b0, "flush off");
    clk_en <= 1'b0;
    fault_cond <= 8'h01;
    wt(10);
    chk1(fault_out, 1'b0, "state frozen while disabled");
    clk_en <= 1'b1;
    wt(10);
    chk1(fault_out, 1'b1, "fault seen once enabled");
    fault_cond <= 8'h00;
    wt(10);
    chk1(fault_out, 1'b0, "fault gone again");
    wstrb <= 4'h1;
    axw(gun_status_pkg::ADDR_FAULT_EN, 32'hffffff05, gun_status_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rchk(gun_status_pkg::ADDR_FAULT_EN, 32'hffffffff, 32'h5);
    fork
      m.pulses(1'b0, 40, 5);
      begin
        wt(300);
        axr(gun_status_pkg::ADDR_FB_FREQ);
        near(rd, 10, 1, "feedback rate");
        axr(gun_status_pkg::ADDR_FLOW);
        near(rd, 10, 1, "flow rate");
        near(32'(flow_out), 20, 3, "flow output scale");
      end
    join
    wt(250);
    rchk(gun_status_pkg::ADDR_FB_FREQ, 32'hffffffff, 32'h0);
    chk(32'(flow_out), 32'h0, "flow output idle");
    m.pulses(1'b1, 7, 4);
    wt(10);
    rchk(gun_status_pkg::ADDR_SOLV_TOT, 32'hffffffff, 32'h7);
    final_report();
  end
endmodule : testbench
`default_nettype wire
